/* inc/lldi_pkg.sv */
// What this block does
// - Controller holds NOP while clocks start
// - Controller waits 200 us before first mode set
// - At least three consecutive mode sets, last valid
// - Consecutive mode sets reset memory logic, then recovery
// - Dummy mode sets drive all address pins low
// - After recovery: refresh eight banks, 1024 NOPs
// - Refreshes may sit anywhere among the NOPs
// - Row cycle time from refresh to same bank
// - No 2048 NOP separation needed between refreshes
// - Upper address bits low during init mode sets
// - Clock or supply change forces loop reset; the block resets the loop only on a dll_reset_in request
// - Command clock phases always cleanly separated
// - Write after write same bank needs row cycle
// - Read after read same bank needs row cycle
// - Write then read needs four NOPs between
// - Four-element write bursts fully captured
// - Write data starts read latency plus one later
// - Masked write elements are discarded
// - Read valid rises early, drops on last element
// - Termination off while driving read data
package lldi_pkg;
    localparam int ADDR_W = 18;
    localparam int BANK_W = 3;
    localparam int NBANK = 8;
    localparam int DATA_W = 18;
    localparam int MEM_AW = 4;
    localparam int PIPE_D = 7;
    // Mode word fields
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_RL_LSB = 2;
    localparam int MODE_TERM_BIT = 4;
    localparam int MODE_DLL_BIT = 7;
    localparam logic [2:0] RL_BASE = 3'h3;
    // Initialization
    localparam int MIN_MRS_RUN = 3;
    localparam logic [10:0] INIT_NOPS = 11'h400;
    localparam logic [10:0] INIT_REFS = 11'h008;
    localparam logic [10:0] DLL_LOCK_TICKS = 11'h400;
    localparam int STABLE_US = 200;
    localparam int CLK_MHZ = 100;
    localparam int STABLE_CYC = STABLE_US * CLK_MHZ;
    localparam logic [3:0] MRSC_TICKS = 4'h6;
    localparam logic [2:0] TRC_TICKS = 3'h4;
    // Controller's fixed configuration
    localparam logic [1:0] CTL_BL_CODE = 2'h1;
    localparam logic [3:0] CTL_BL = 4'h4;
    localparam logic [1:0] CTL_RL_SEL = 2'h1;
    localparam logic CTL_TERM = 1'b1;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_MRS = 3'h1,
        CMD_REF = 3'h2,
        CMD_RD = 3'h3,
        CMD_WR = 3'h4
    } lldi_cmd_t;

    function automatic logic [3:0] bl_elems(input logic [1:0] code);
        case (code)
            2'h0: bl_elems = 4'h2;
            2'h1: bl_elems = 4'h4;
            default: bl_elems = 4'h8;
        endcase
    endfunction

    function automatic logic [2:0] rl_cycles(input logic [1:0] sel);
        rl_cycles = {1'b0, sel} + RL_BASE;
    endfunction
endpackage

/* inc/lldi_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lldi_link_if;
    logic link_clk;
    lldi_pkg::lldi_cmd_t cmd;
    logic [lldi_pkg::BANK_W-1:0] bank;
    logic [lldi_pkg::ADDR_W-1:0] addr;
    logic [lldi_pkg::DATA_W-1:0] ctl_dq;
    logic ctl_dq_oe;
    logic [lldi_pkg::DATA_W-1:0] dev_dq;
    logic dev_dq_oe;
    logic [lldi_pkg::DATA_W-1:0] dq;
    logic wmask;
    logic rvalid;
    // Shared data wire; an undriven bus reads as zero
    assign dq = ctl_dq_oe ? ctl_dq : (dev_dq_oe ? dev_dq : '0);
    modport ctl (
        output link_clk, cmd, bank, addr, ctl_dq, ctl_dq_oe, wmask,
        input dq, rvalid
    );
    modport dev (
        input link_clk, cmd, bank, addr, wmask, dq,
        output dev_dq, dev_dq_oe, rvalid
    );
endinterface
`default_nettype wire

/* hdl/lldi_mem_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module lldi_mem_dev (
    // Link
    lldi_link_if.dev link,
    // User side
    input wire logic clk_in,
    input wire logic sys_rst_in,
    output logic ready_out,
    output logic term_on_out,
    output logic proto_err_out
);
    typedef enum logic [2:0] {
        PH_OFF = 3'h1,
        PH_INIT = 3'h2,
        PH_RUN = 3'h4
    } lldi_phase_t;

    function automatic logic [6:0] next_word(input logic [6:0] p);
        next_word = {p[6:4], p[3:0] + 4'h1};
    endfunction

    logic rst_meta_q, lrst_q;
    lldi_phase_t ph_q, ph_d;
    logic [1:0] run_q, run_d;
    logic [lldi_pkg::ADDR_W-1:0] mode_q, mode_d;
    logic [7:0] refm_q, refm_d;
    logic [10:0] nop_q, nop_d;
    logic err_q, err_d;
    logic [7:0] rpipe_q [lldi_pkg::PIPE_D];
    logic [7:0] rpipe_d [lldi_pkg::PIPE_D];
    logic [7:0] wpipe_q [lldi_pkg::PIPE_D];
    logic [7:0] wpipe_d [lldi_pkg::PIPE_D];
    logic [3:0] rleft_q, rleft_d, wleft_q, wleft_d;
    logic [6:0] rptr_q, rptr_d, wptr_q, wptr_d;
    logic [lldi_pkg::DATA_W-1:0] dq_q, dq_d;
    logic oe_q, oe_d, term_q, term_d, read_valid_flag_q, read_valid_flag_d;
    logic mem_we;
    logic [6:0] mem_wa;
    logic [lldi_pkg::DATA_W-1:0] mem_q [128];
    logic [2:0] rl;
    logic [3:0] bl;
    logic [7:0] tok;
    logic [2:0] sync1_q, sync2_q;

    // The link clock is still while the controller is in reset, so reset must act without it
    always_ff @(posedge link.link_clk or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rst_meta_q <= 1'b1;
            lrst_q <= 1'b1;
        end else begin
            rst_meta_q <= 1'b0;
            lrst_q <= rst_meta_q;
        end
    end

    always_comb begin
        rl = lldi_pkg::rl_cycles(mode_q[lldi_pkg::MODE_RL_LSB +: 2]);
        bl = lldi_pkg::bl_elems(mode_q[lldi_pkg::MODE_BL_LSB +: 2]);
        tok = {1'b1, link.bank, link.addr[lldi_pkg::MEM_AW-1:0]};
        ph_d = ph_q;
        mode_d = mode_q;
        refm_d = refm_q;
        nop_d = nop_q;
        err_d = err_q;
        for (int i = 0; i < lldi_pkg::PIPE_D - 1; i++) begin
            rpipe_d[i] = rpipe_q[i+1];
            wpipe_d[i] = wpipe_q[i+1];
        end
        rpipe_d[lldi_pkg::PIPE_D-1] = '0;
        wpipe_d[lldi_pkg::PIPE_D-1] = '0;
        rleft_d = rleft_q;
        rptr_d = rptr_q;
        wleft_d = wleft_q;
        wptr_d = wptr_q;
        dq_d = '0;
        oe_d = 1'b0;
        mem_we = 1'b0;
        mem_wa = wptr_q;
        // Read bursts: element k leaves on edge cmd + read latency + k
        if (rpipe_q[0][7]) begin
            dq_d = mem_q[rpipe_q[0][6:0]];
            oe_d = 1'b1;
            rleft_d = bl - 4'h1;
            rptr_d = next_word(rpipe_q[0][6:0]);
        end else if (rleft_q != 4'h0) begin
            dq_d = mem_q[rptr_q];
            oe_d = 1'b1;
            rleft_d = rleft_q - 4'h1;
            rptr_d = next_word(rptr_q);
        end
        // Write bursts: first element on edge cmd + read latency + 1
        if (wpipe_q[0][7]) begin
            mem_we = ~link.wmask;
            mem_wa = wpipe_q[0][6:0];
            wleft_d = bl - 4'h1;
            wptr_d = next_word(wpipe_q[0][6:0]);
        end else if (wleft_q != 4'h0) begin
            mem_we = ~link.wmask;
            wleft_d = wleft_q - 4'h1;
            wptr_d = next_word(wptr_q);
        end
        if (link.cmd == lldi_pkg::CMD_MRS) begin
            mode_d = link.addr;
            run_d = (run_q == 2'h3) ? run_q : run_q + 2'h1;
            // Third back-to-back mode set resets the logic; recovery refreshes and NOPs must follow
            if (run_q >= 2'h2) begin
                ph_d = PH_INIT;
                refm_d = '0;
                nop_d = '0;
                for (int i = 0; i < lldi_pkg::PIPE_D; i++) begin
                    rpipe_d[i] = '0;
                    wpipe_d[i] = '0;
                end
                rleft_d = '0;
                wleft_d = '0;
                oe_d = 1'b0;
                mem_we = 1'b0;
            end
        end else begin
            run_d = '0;
            case (ph_q)
                PH_INIT: begin
                    // Any interleaving of refreshes and NOPs counts
                    if (link.cmd == lldi_pkg::CMD_REF) begin
                        refm_d = refm_q | (8'h01 << link.bank);
                    end else if (link.cmd == lldi_pkg::CMD_NOP && nop_q != lldi_pkg::INIT_NOPS) begin
                        nop_d = nop_q + 11'h001;
                    end else if (link.cmd == lldi_pkg::CMD_RD || link.cmd == lldi_pkg::CMD_WR) begin
                        err_d = 1'b1;
                    end
                    if (refm_d == 8'hFF && nop_d == lldi_pkg::INIT_NOPS) begin
                        ph_d = PH_RUN;
                    end
                end
                PH_RUN: begin
                    if (link.cmd == lldi_pkg::CMD_RD) begin
                        if (!mode_q[lldi_pkg::MODE_DLL_BIT]) begin
                            err_d = 1'b1;
                        end else begin
                            rpipe_d[rl - 3'h1] = tok;
                        end
                    end else if (link.cmd == lldi_pkg::CMD_WR) begin
                        wpipe_d[rl] = tok;
                    end
                end
                default: begin
                    if (link.cmd == lldi_pkg::CMD_RD || link.cmd == lldi_pkg::CMD_WR) begin
                        err_d = 1'b1;
                    end
                end
            endcase
        end
        term_d = mode_q[lldi_pkg::MODE_TERM_BIT] & ~oe_d;
        // Sampled half a cycle ahead of the element it announces
        read_valid_flag_d = rpipe_q[0][7] | (rleft_q != 4'h0);
    end

    always_ff @(posedge link.link_clk or posedge lrst_q) begin
        if (lrst_q) begin
            ph_q <= PH_OFF;
            run_q <= '0;
            mode_q <= '0;
            refm_q <= '0;
            nop_q <= '0;
            err_q <= 1'b0;
            for (int i = 0; i < lldi_pkg::PIPE_D; i++) begin
                rpipe_q[i] <= '0;
                wpipe_q[i] <= '0;
            end
            rleft_q <= '0;
            rptr_q <= '0;
            wleft_q <= '0;
            wptr_q <= '0;
            dq_q <= '0;
            oe_q <= 1'b0;
            term_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            run_q <= run_d;
            mode_q <= mode_d;
            refm_q <= refm_d;
            nop_q <= nop_d;
            err_q <= err_d;
            rpipe_q <= rpipe_d;
            wpipe_q <= wpipe_d;
            rleft_q <= rleft_d;
            rptr_q <= rptr_d;
            wleft_q <= wleft_d;
            wptr_q <= wptr_d;
            dq_q <= dq_d;
            oe_q <= oe_d;
            term_q <= term_d;
        end
    end

    always_ff @(posedge link.link_clk) begin
        if (mem_we) begin
            mem_q[mem_wa] <= link.dq;
        end
    end

    always_ff @(negedge link.link_clk or posedge lrst_q) begin
        if (lrst_q) begin
            read_valid_flag_q <= 1'b0;
        end else begin
            read_valid_flag_q <= read_valid_flag_d;
        end
    end

    assign link.dev_dq = dq_q;
    assign link.dev_dq_oe = oe_q;
    assign link.rvalid = read_valid_flag_q;

    // Status levels cross into the user clock
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {err_q, term_q, ph_q == PH_RUN};
            sync2_q <= sync1_q;
        end
    end

    assign ready_out = sync2_q[0];
    assign term_on_out = sync2_q[1];
    assign proto_err_out = sync2_q[2];
endmodule
`default_nettype wire

/* hdl/lldi_mem_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module lldi_mem_ctl #(
    parameter int STABLE_CYCLES = lldi_pkg::STABLE_CYC
) (
    // Link
    lldi_link_if.ctl link,
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Requests
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [lldi_pkg::BANK_W-1:0] req_bank_in,
    input wire logic [lldi_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [lldi_pkg::CTL_BL*lldi_pkg::DATA_W-1:0] wr_data_in,
    input wire logic [lldi_pkg::CTL_BL-1:0] wr_mask_in,
    output logic req_ready_out,
    // Read return
    output logic [lldi_pkg::DATA_W-1:0] rd_data_out,
    output logic rd_valid_out,
    // Maintenance and status
    input wire logic dll_reset_in,
    output logic init_done_out
);
    typedef enum logic [5:0] {
        ST_STABLE = 6'h01,
        ST_MRS = 6'h02,
        ST_MRSC = 6'h04,
        ST_REF = 6'h08,
        ST_RUN = 6'h10,
        ST_DLL = 6'h20
    } lldi_ctl_state_t;

    // Upper address bits stay zero in every mode word
    function automatic logic [lldi_pkg::ADDR_W-1:0] mode_word(input logic dll_on);
        mode_word = '0;
        mode_word[lldi_pkg::MODE_BL_LSB +: 2] = lldi_pkg::CTL_BL_CODE;
        mode_word[lldi_pkg::MODE_RL_LSB +: 2] = lldi_pkg::CTL_RL_SEL;
        mode_word[lldi_pkg::MODE_TERM_BIT] = lldi_pkg::CTL_TERM;
        mode_word[lldi_pkg::MODE_DLL_BIT] = dll_on;
    endfunction

    logic div_q, div_d;
    lldi_ctl_state_t st_q, st_d;
    logic [15:0] wait_q, wait_d;
    logic [1:0] mrs_n_q, mrs_n_d;
    logic [10:0] slot_q, slot_d;
    logic [10:0] lock_q, lock_d;
    logic dll_pend_q, dll_pend_d;
    logic [2:0] trc_q [lldi_pkg::NBANK];
    logic [2:0] trc_d [lldi_pkg::NBANK];
    logic [3:0] turn_q, turn_d;
    logic turn_wr_q, turn_wr_d;
    logic wr_busy_q, wr_busy_d;
    logic [3:0] wr_wait_q, wr_wait_d;
    logic [2:0] wr_idx_q, wr_idx_d;
    logic [lldi_pkg::CTL_BL*lldi_pkg::DATA_W-1:0] wbuf_q, wbuf_d;
    logic [lldi_pkg::CTL_BL-1:0] wmbuf_q, wmbuf_d;
    lldi_pkg::lldi_cmd_t cmd_q, cmd_d;
    logic [lldi_pkg::BANK_W-1:0] bank_q, bank_d;
    logic [lldi_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [lldi_pkg::DATA_W-1:0] dq_q, dq_d;
    logic oe_q, oe_d, wm_q, wm_d;
    logic [lldi_pkg::DATA_W-1:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic tick;
    logic [3:0] wl;

    // Link falls on the clk_in edge after a tick; commands change there and are stable at the rise
    assign tick = div_q;
    assign wl = {1'b0, lldi_pkg::rl_cycles(lldi_pkg::CTL_RL_SEL)} + 4'h1;

    // Bank countdown gates same-bank commands
    always_comb begin
        req_ready_out = 1'b0;
        if (tick && st_q == ST_RUN && !dll_pend_q && trc_q[req_bank_in] == 3'h0) begin
            if (req_write_in) begin
                req_ready_out = !wr_busy_q && !(turn_q != 4'h0 && !turn_wr_q);
            end else begin
                // Reads wait out the turnaround after a write
                req_ready_out = lock_q == 11'h000 && !(turn_q != 4'h0 && turn_wr_q);
            end
        end
    end

    always_comb begin
        div_d = ~div_q;
        st_d = st_q;
        wait_d = wait_q;
        mrs_n_d = mrs_n_q;
        slot_d = slot_q;
        lock_d = lock_q;
        dll_pend_d = dll_pend_q;
        trc_d = trc_q;
        turn_d = turn_q;
        turn_wr_d = turn_wr_q;
        wr_busy_d = wr_busy_q;
        wr_wait_d = wr_wait_q;
        wr_idx_d = wr_idx_q;
        wbuf_d = wbuf_q;
        wmbuf_d = wmbuf_q;
        cmd_d = cmd_q;
        bank_d = bank_q;
        addr_d = addr_q;
        dq_d = dq_q;
        oe_d = oe_q;
        wm_d = wm_q;
        rd_data_d = rd_data_q;
        rd_valid_d = 1'b0;
        if (st_q == ST_STABLE) begin
            wait_d = wait_q + 16'h0001;
            if (wait_q == 16'(STABLE_CYCLES - 1)) begin
                st_d = ST_MRS;
                wait_d = '0;
            end
        end
        if (tick) begin
            cmd_d = lldi_pkg::CMD_NOP;
            bank_d = '0;
            addr_d = '0;
            for (int i = 0; i < lldi_pkg::NBANK; i++) begin
                if (trc_q[i] != 3'h0) begin
                    trc_d[i] = trc_q[i] - 3'h1;
                end
            end
            if (turn_q != 4'h0) begin
                turn_d = turn_q - 4'h1;
            end
            if (lock_q != 11'h000) begin
                lock_d = lock_q - 11'h001;
            end
            // Valid flag seen here belongs to the element now on the bus
            if (link.rvalid) begin
                rd_data_d = link.dq;
                rd_valid_d = 1'b1;
            end
            if (wr_busy_q) begin
                if (wr_wait_q > 4'h1) begin
                    wr_wait_d = wr_wait_q - 4'h1;
                end else if ({1'b0, wr_idx_q} < lldi_pkg::CTL_BL) begin
                    wr_wait_d = '0;
                    dq_d = wbuf_q[wr_idx_q*lldi_pkg::DATA_W +: lldi_pkg::DATA_W];
                    wm_d = wmbuf_q[wr_idx_q[1:0]];
                    oe_d = 1'b1;
                    wr_idx_d = wr_idx_q + 3'h1;
                end else begin
                    oe_d = 1'b0;
                    wm_d = 1'b0;
                    wr_busy_d = 1'b0;
                end
            end
            case (st_q)
                ST_MRS: begin
                    // Dummies carry an all-low address, the last carries the mode
                    cmd_d = lldi_pkg::CMD_MRS;
                    if (mrs_n_q == 2'(lldi_pkg::MIN_MRS_RUN - 1)) begin
                        addr_d = mode_word(1'b1);
                        st_d = ST_MRSC;
                        wait_d = '0;
                    end else begin
                        mrs_n_d = mrs_n_q + 2'h1;
                    end
                end
                ST_MRSC: begin
                    wait_d = wait_q + 16'h0001;
                    if (wait_q == {12'h000, lldi_pkg::MRSC_TICKS - 4'h1}) begin
                        st_d = ST_REF;
                        slot_d = '0;
                    end
                end
                ST_REF: begin
                    // Refreshes go first, then the NOPs; any placement is legal
                    if (slot_q < lldi_pkg::INIT_REFS) begin
                        cmd_d = lldi_pkg::CMD_REF;
                        bank_d = slot_q[2:0];
                        trc_d[slot_q[2:0]] = lldi_pkg::TRC_TICKS - 3'h1;
                    end
                    slot_d = slot_q + 11'h001;
                    if (slot_q == lldi_pkg::INIT_NOPS + lldi_pkg::INIT_REFS - 11'h001) begin
                        st_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (dll_pend_q) begin
                        // First half of the loop reset: mode set with the loop off
                        cmd_d = lldi_pkg::CMD_MRS;
                        addr_d = mode_word(1'b0);
                        dll_pend_d = 1'b0;
                        st_d = ST_DLL;
                        wait_d = '0;
                    end else if (req_valid_in && req_ready_out) begin
                        cmd_d = req_write_in ? lldi_pkg::CMD_WR : lldi_pkg::CMD_RD;
                        bank_d = req_bank_in;
                        addr_d = req_addr_in;
                        trc_d[req_bank_in] = lldi_pkg::TRC_TICKS - 3'h1;
                        turn_d = lldi_pkg::CTL_BL;
                        turn_wr_d = req_write_in;
                        if (req_write_in) begin
                            wbuf_d = wr_data_in;
                            wmbuf_d = wr_mask_in;
                            wr_busy_d = 1'b1;
                            wr_wait_d = wl;
                            wr_idx_d = '0;
                        end
                    end
                end
                ST_DLL: begin
                    wait_d = wait_q + 16'h0001;
                    if (wait_q == {12'h000, lldi_pkg::MRSC_TICKS - 4'h1}) begin
                        cmd_d = lldi_pkg::CMD_MRS;
                        addr_d = mode_word(1'b1);
                        lock_d = lldi_pkg::DLL_LOCK_TICKS;
                        st_d = ST_RUN;
                    end
                end
                default: begin
                end
            endcase
        end
        // A request arriving as the pending one is consumed is kept
        if (dll_reset_in) begin
            dll_pend_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            div_q <= 1'b0;
            st_q <= ST_STABLE;
            wait_q <= '0;
            mrs_n_q <= '0;
            slot_q <= '0;
            lock_q <= '0;
            dll_pend_q <= 1'b0;
            for (int i = 0; i < lldi_pkg::NBANK; i++) begin
                trc_q[i] <= '0;
            end
            turn_q <= '0;
            turn_wr_q <= 1'b0;
            wr_busy_q <= 1'b0;
            wr_wait_q <= '0;
            wr_idx_q <= '0;
            wbuf_q <= '0;
            wmbuf_q <= '0;
            cmd_q <= lldi_pkg::CMD_NOP;
            bank_q <= '0;
            addr_q <= '0;
            dq_q <= '0;
            oe_q <= 1'b0;
            wm_q <= 1'b0;
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end else begin
            div_q <= div_d;
            st_q <= st_d;
            wait_q <= wait_d;
            mrs_n_q <= mrs_n_d;
            slot_q <= slot_d;
            lock_q <= lock_d;
            dll_pend_q <= dll_pend_d;
            trc_q <= trc_d;
            turn_q <= turn_d;
            turn_wr_q <= turn_wr_d;
            wr_busy_q <= wr_busy_d;
            wr_wait_q <= wr_wait_d;
            wr_idx_q <= wr_idx_d;
            wbuf_q <= wbuf_d;
            wmbuf_q <= wmbuf_d;
            cmd_q <= cmd_d;
            bank_q <= bank_d;
            addr_q <= addr_d;
            dq_q <= dq_d;
            oe_q <= oe_d;
            wm_q <= wm_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // Clock straight from a flop: no glitch, phases never overlap
    assign link.link_clk = div_q;
    assign link.cmd = cmd_q;
    assign link.bank = bank_q;
    assign link.addr = addr_q;
    assign link.ctl_dq = dq_q;
    assign link.ctl_dq_oe = oe_q;
    assign link.wmask = wm_q;
    assign rd_data_out = rd_data_q;
    assign rd_valid_out = rd_valid_q;
    assign init_done_out = st_q == ST_RUN;
endmodule
`default_nettype wire

/* testbench/lldi_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module lldi_chk (
    // Link
    input wire logic link_clk,
    input wire logic sys_rst_in,
    input wire lldi_pkg::lldi_cmd_t cmd,
    input wire logic [2:0] bank,
    input wire logic [17:0] addr,
    input wire logic ctl_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic rvalid
);
    default clocking @(posedge link_clk); endclocking
    default disable iff (sys_rst_in);
    a_upper_addr_low: assert property (cmd == lldi_pkg::CMD_MRS |-> addr[17:10] == 8'h00)
        else $error("upper address bits set");
    a_mode_set_run: assert property (cmd == lldi_pkg::CMD_MRS && addr == 18'h00000 && $past(cmd) != cmd
        |=> cmd == lldi_pkg::CMD_MRS ##1 cmd == lldi_pkg::CMD_MRS && addr[7]) else $error("short mode set run");
    a_row_cycle: assert property (cmd > lldi_pkg::CMD_MRS |->
        !($past(cmd) > lldi_pkg::CMD_MRS && $past(bank) == bank)
        && !($past(cmd, 2) > lldi_pkg::CMD_MRS && $past(bank, 2) == bank)
        && !($past(cmd, 3) > lldi_pkg::CMD_MRS && $past(bank, 3) == bank)) else $error("row cycle broken");
    a_write_latency: assert property (cmd == lldi_pkg::CMD_WR |-> ##5 ctl_dq_oe [*4] ##1 !ctl_dq_oe)
        else $error("write data misplaced");
    a_read_valid_lead: assert property (cmd == lldi_pkg::CMD_RD |-> ##4 rvalid ##1 dev_dq_oe [*4])
        else $error("read valid not early");
    a_valid_last: assert property ($fell(rvalid) |-> dev_dq_oe ##1 !dev_dq_oe)
        else $error("read valid not on last");
    a_no_contention: assert property (!(ctl_dq_oe && dev_dq_oe))
        else $error("data bus contention");
    a_write_read_gap: assert property (cmd == lldi_pkg::CMD_WR |=> (cmd != lldi_pkg::CMD_RD) [*4])
        else $error("read too soon");
endmodule
`default_nettype wire

/* testbench/test_lowlatency_dram_init_and_command_spacing.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) checks_done++; if ((g) !== (e)) begin failures++; $display("Error %s exp %h got %h", n, e, g); end
module test_lowlatency_dram_init_and_command_spacing;
    logic clk_in = 1'h0, sys_rst_in = 1'h1, req_valid_in = 1'h0, req_write_in = 1'h0, dll_reset_in = 1'h0;
    logic [2:0] req_bank_in = 3'h0;
    logic [17:0] req_addr_in = 18'h00000, rd_data_out;
    logic [71:0] wr_data_in = 72'h0;
    logic [3:0] wr_mask_in = 4'h0;
    logic req_ready_out, rd_valid_out, init_done_out, ready_out, term_on_out, proto_err_out;
    int failures = 0, checks_done = 0;
    // Second write masks element 2, so the first write's element survives there
    localparam logic [71:0] merged = {18'h25555, 18'h12222, 18'h27777, 18'h28888};
    always #5 clk_in = ~clk_in;
    lldi_link_if link_if ();
    lldi_mem_ctl #(.STABLE_CYCLES(50)) lldi_mem_ctl_i (.link(link_if), .clk_in, .sys_rst_in, .req_valid_in,
        .req_write_in, .req_bank_in, .req_addr_in, .wr_data_in, .wr_mask_in, .req_ready_out, .rd_data_out,
        .rd_valid_out, .dll_reset_in, .init_done_out);
    lldi_mem_dev lldi_mem_dev_i (.link(link_if), .clk_in, .sys_rst_in, .ready_out, .term_on_out, .proto_err_out);
    lldi_chk lldi_chk_i (.link_clk(link_if.link_clk), .sys_rst_in, .cmd(link_if.cmd), .bank(link_if.bank),
        .addr(link_if.addr), .ctl_dq_oe(link_if.ctl_dq_oe), .dev_dq_oe(link_if.dev_dq_oe), .rvalid(link_if.rvalid));
    task automatic finish_test();
        $display("Checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Ready is only offered on tick cycles, so the request is held until it is taken
    task automatic issue(input logic wr, input logic [2:0] b, input logic [71:0] d, input logic [3:0] m);
        int n = 0;
        @(posedge clk_in);
        req_valid_in <= 1'h1;
        req_write_in <= wr;
        req_bank_in <= b;
        wr_data_in <= d;
        wr_mask_in <= m;
        do begin
            @(posedge clk_in);
            n++;
        end while (req_ready_out !== 1'h1 && n < 3000);
        `CHK("request taken", 1'h1, req_ready_out)
        req_valid_in <= 1'h0;
    endtask
    task automatic read_chk(input logic [2:0] b);
        int k = 0;
        int n = 0;
        issue(1'h0, b, 72'h0, 4'h0);
        while (k < 4 && n < 40) begin
            @(posedge clk_in);
            n++;
            if (rd_valid_out === 1'h1) begin
                `CHK("read data", merged[18*k +: 18], rd_data_out)
                k++;
            end
        end
        `CHK("read elements", 4, k)
    endtask
    task automatic t_init();
        int n = 0;
        // The device may count the recovery NOPs and finish before the controller does
        while ((ready_out !== 1'h1 || init_done_out !== 1'h1) && n < 20000) begin
            @(posedge clk_in);
            n++;
        end
        `CHK("device ready", 1'h1, ready_out)
        `CHK("init done", 1'h1, init_done_out)
        `CHK("termination", 1'h1, term_on_out)
    endtask
    task automatic t_masked_write();
        issue(1'h1, 3'h1, {18'h11111, 18'h12222, 18'h13333, 18'h14444}, 4'h0);
        issue(1'h1, 3'h1, {18'h25555, 18'h26666, 18'h27777, 18'h28888}, 4'h4);
        read_chk(3'h1);
        read_chk(3'h1);
    endtask
    task automatic t_dll_reset();
        @(posedge clk_in);
        dll_reset_in <= 1'h1;
        @(posedge clk_in);
        dll_reset_in <= 1'h0;
        read_chk(3'h1);
        `CHK("protocol error", 1'h0, proto_err_out)
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        t_init();
        t_masked_write();
        t_dll_reset();
        finish_test();
    end
    initial begin
        #400000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
